// >>> logic/msr_pkg.sv
`default_nettype none
package msr_pkg;

   // ----------------------------------------------------------------
   // Register offsets on the serial register port.
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_WM_STATUS = 8'h39;
   localparam logic [7:0] OFS_GYRO_X_HIGH = 8'h43;
   localparam logic [7:0] OFS_GYRO_X_LOW = 8'h44;
   localparam logic [7:0] OFS_GYRO_Y_HIGH = 8'h45;
   localparam logic [7:0] OFS_GYRO_Y_LOW = 8'h46;
   localparam logic [7:0] OFS_GYRO_Z_HIGH = 8'h47;
   localparam logic [7:0] OFS_GYRO_Z_LOW = 8'h48;
   localparam logic [7:0] OFS_FACTORY_ST_X = 8'h50;
   localparam logic [7:0] OFS_FACTORY_ST_Y = 8'h51;
   localparam logic [7:0] OFS_FACTORY_ST_Z = 8'h52;
   localparam logic [7:0] OFS_WM_THRESH_HIGH = 8'h60;
   localparam logic [7:0] OFS_WM_THRESH_LOW = 8'h61;
   localparam logic [7:0] OFS_PATH_RESET = 8'h68;
   localparam logic [7:0] OFS_MOTION_CTRL = 8'h69;
   localparam logic [7:0] OFS_FIFO_DATA = 8'h74;

   // ----------------------------------------------------------------
   // Field positions and widths.
   // ----------------------------------------------------------------
   localparam int WM_FLAG_BIT = 6;
   localparam int THR_W = 10;
   localparam int PATH_RST_ACCEL_BIT = 1;
   localparam int PATH_RST_TEMP_BIT = 0;
   localparam int MOT_EN_BIT = 7;
   localparam int MOT_COMPARE_BIT = 6;
   localparam int MOT_UNLIMIT_BIT = 1;
   localparam int MOT_COMBINE_BIT = 0;
   localparam logic [7:0] MOT_CTRL_MASK = 8'hC3;

   // ----------------------------------------------------------------
   // Reset values and limits.
   // ----------------------------------------------------------------
   localparam logic [7:0] THR_RESET = 8'h00;
   localparam logic [7:0] MOT_CTRL_RESET = 8'h00;
   localparam logic [15:0] RATE_LIMIT = 16'h7FFF;
   localparam logic [15:0] RATE_LIMITED = 16'h7FFE;

   // ----------------------------------------------------------------
   // Timing: interrupt pulse width.
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned WM_PULSE_US = 50;
   localparam int unsigned WM_PULSE_CYC = WM_PULSE_US * CLK_MHZ;
   localparam int PULSE_CNT_W = 16;

   // Interrupt pin sequencer states.
   typedef enum logic [2:0]
   {
      PIN_IDLE = 3'b001,
      PIN_PULSE = 3'b010,
      PIN_HOLD = 3'b100
   } msr_pin_state_t;

endpackage
`default_nettype wire

// >>> logic/msr_wm_if.sv
`default_nettype none
interface msr_wm_if;
   import msr_pkg::*;

   // Threshold, level and read activity from the register bank.
   logic [THR_W-1:0] thr;
   logic [15:0] count;
   logic data_rd;
   logic xfer_end;
   logic latch_mode;
   // Status and pin back from the watermark engine.
   logic flag;
   logic pin;

   modport engine (input thr, count, data_rd, xfer_end, latch_mode, output flag, pin);
   modport ctrl (output thr, count, data_rd, xfer_end, latch_mode, input flag, pin);
endinterface
`default_nettype wire

// >>> logic/msr_wm.sv
`default_nettype none
module msr_wm
   import msr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = WM_PULSE_CYC
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Link to the register bank.
   msr_wm_if.engine wm
);

   typedef struct packed {
      logic in_read;
      logic flag;
      logic pin;
      msr_pin_state_t pst;
      logic [PULSE_CNT_W-1:0] cnt;
   } msr_wm_st_t;

   msr_wm_st_t st_r;
   msr_wm_st_t st_nxt;
   logic reading;
   logic first_rd;
   logic above;
   logic trig;

   // ----------------------------------------------------------------
   // Watermark detection and interrupt pin sequencing.
   // ----------------------------------------------------------------

   // A read window runs from the first data byte to the end of the transfer.
   always_comb
   begin
      st_nxt = st_r;
      reading = st_r.in_read | wm.data_rd;
      first_rd = wm.data_rd & ~st_r.in_read;
      above = (wm.thr != '0) && (wm.count >= {6'h00, wm.thr});
      trig = above & ~reading & ~st_r.flag;
      st_nxt.in_read = reading & ~wm.xfer_end;
      // Only the first data read clears; a fresh trigger cannot coincide with it.
      if (trig)
      begin
         st_nxt.flag = 1'b1;
      end
      else if (first_rd)
      begin
         st_nxt.flag = 1'b0;
      end
      case (st_r.pst)
         PIN_IDLE:
         begin
            if (trig && wm.latch_mode)
            begin
               st_nxt.pst = PIN_HOLD;
               st_nxt.pin = 1'b1;
            end
            else if (trig)
            begin
               st_nxt.pst = PIN_PULSE;
               st_nxt.pin = 1'b1;
               st_nxt.cnt = PULSE_CNT_W'(PULSE_CYC - 1);
            end
         end
         PIN_PULSE:
         begin
            // A retrigger during a pulse restarts it rather than being lost.
            if (trig)
            begin
               st_nxt.cnt = PULSE_CNT_W'(PULSE_CYC - 1);
            end
            else if (st_r.cnt == '0)
            begin
               st_nxt.pst = PIN_IDLE;
               st_nxt.pin = 1'b0;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         PIN_HOLD:
         begin
            if (first_rd)
            begin
               st_nxt.pst = PIN_IDLE;
               st_nxt.pin = 1'b0;
            end
         end
         default:
         begin
            st_nxt.pst = PIN_IDLE;
            st_nxt.pin = 1'b0;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '{in_read: 1'b0, flag: 1'b0, pin: 1'b0, pst: PIN_IDLE, cnt: '0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign wm.flag = st_r.flag;
   assign wm.pin = st_r.pin;

endmodule // msr_wm
`default_nettype wire

// >>> logic/msr_regs.sv
`default_nettype none
module msr_regs
   import msr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = WM_PULSE_CYC
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register access from the serial interface engine.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic xfer_end,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // Gyro datapath, already scaled to counts.
   input wire logic sample_valid,
   input wire logic [15:0] rate_x_in,
   input wire logic [15:0] rate_y_in,
   input wire logic [15:0] rate_z_in,
   // Factory self-test values from one-time storage.
   input wire logic [7:0] x_factory_test_value,
   input wire logic [7:0] y_factory_test_value,
   input wire logic [7:0] z_factory_test_value,
   // FIFO storage side.
   input wire logic [15:0] fifo_count,
   input wire logic [7:0] fifo_rdata,
   output logic fifo_pop,
   // Interrupt pin.
   input wire logic int_latch_mode,
   output logic int_pin,
   // Signal path resets.
   output logic accel_path_reset,
   output logic temp_path_reset,
   // Wake-on-motion.
   input wire logic [2:0] axis_over,
   input wire logic [2:0] axis_enable,
   output logic motion_detect_enable,
   output logic motion_compare_mode,
   output logic output_unlimit,
   output logic motion_axis_combine,
   output logic motion_event
);

   typedef struct packed {
      // The latest rate words are kept here.
      logic [15:0] rate_x_word;
      logic [15:0] rate_y_word;
      logic [15:0] rate_z_word;
      // Self-test copies and the marker of their first load.
      logic st_loaded;
      logic [7:0] st_x;
      logic [7:0] st_y;
      logic [7:0] st_z;
      // The threshold is stored as the two halves of the bus.
      logic [1:0] thr_high;
      logic [7:0] thr_low;
      // Motion control bits and the path reset pulses.
      logic [7:0] mot_ctrl;
      logic accel_rst;
      logic temp_rst;
      // The read answer and the queue pop.
      logic [7:0] rdata;
      logic rvalid;
      logic pop;
      // The registered motion decision.
      logic motion;
   } msr_regs_st_t;

   msr_regs_st_t st_r;
   msr_regs_st_t st_nxt;
   logic data_rd;

   msr_wm_if wm_if ();

   // ----------------------------------------------------------------
   // Helper functions.
   // ----------------------------------------------------------------

   // Without the unlimit bit a full positive word is pulled one count down.
   function automatic logic [15:0] limit_rate(input logic [15:0] w, input logic unlim);
      if (!unlim && w == RATE_LIMIT)
      begin
         limit_rate = RATE_LIMITED;
      end
      else
      begin
         limit_rate = w;
      end
   endfunction

   // Combine per-axis threshold hits across the enabled axes.
   // An AND over no enabled axis stays low rather than firing on nothing.
   function automatic logic combine_axes(input logic [2:0] hit, input logic [2:0] en,
                                         input logic use_and);
      if (use_and)
      begin
         combine_axes = (|en) && (&(hit | ~en));
      end
      else
      begin
         combine_axes = |(hit & en);
      end
   endfunction

   // ----------------------------------------------------------------
   // Watermark engine.
   // ----------------------------------------------------------------

   // Any read of the queue data offset counts as a data read.
   assign data_rd = reg_rd && (reg_addr == OFS_FIFO_DATA);

   // The threshold and read activity go to the engine straight from the bank.
   assign wm_if.thr = {st_r.thr_high, st_r.thr_low};
   assign wm_if.count = fifo_count;
   assign wm_if.data_rd = data_rd;
   assign wm_if.xfer_end = xfer_end;
   assign wm_if.latch_mode = int_latch_mode;

   // The engine owns the flag and the pin; the bank only reads them back.
   msr_wm #(
      .PULSE_CYC(PULSE_CYC)
   ) u_wm (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .wm(wm_if.engine)
   );

   // ----------------------------------------------------------------
   // Register bank next state.
   // ----------------------------------------------------------------

   always_comb
   begin
      st_nxt = st_r;
      // Strobes default low; only a request in this cycle raises them.
      st_nxt.accel_rst = 1'b0;
      st_nxt.temp_rst = 1'b0;
      st_nxt.rvalid = reg_rd;
      st_nxt.pop = data_rd;

      // Self-test values are copied in once after reset, then software owns them.
      if (!st_r.st_loaded)
      begin
         st_nxt.st_loaded = 1'b1;
         st_nxt.st_x = x_factory_test_value;
         st_nxt.st_y = y_factory_test_value;
         st_nxt.st_z = z_factory_test_value;
      end

      // Scaling lives in the datapath; the bank only applies the output limit.
      if (sample_valid)
      begin
         st_nxt.rate_x_word = limit_rate(rate_x_in, st_r.mot_ctrl[MOT_UNLIMIT_BIT]);
         st_nxt.rate_y_word = limit_rate(rate_y_in, st_r.mot_ctrl[MOT_UNLIMIT_BIT]);
         st_nxt.rate_z_word = limit_rate(rate_z_in, st_r.mot_ctrl[MOT_UNLIMIT_BIT]);
      end

      // Register writes; read-only offsets and unmapped offsets are ignored.
      if (reg_wr)
      begin
         case (reg_addr)
            // Software may overwrite the self-test copies.
            OFS_FACTORY_ST_X: st_nxt.st_x = reg_wdata;
            OFS_FACTORY_ST_Y: st_nxt.st_y = reg_wdata;
            OFS_FACTORY_ST_Z: st_nxt.st_z = reg_wdata;
            // The threshold arrives as two halves.
            OFS_WM_THRESH_HIGH: st_nxt.thr_high = reg_wdata[1:0];
            OFS_WM_THRESH_LOW: st_nxt.thr_low = reg_wdata;
            OFS_PATH_RESET:
            begin
               // Path resets leave the sensor words alone.
               st_nxt.accel_rst = reg_wdata[PATH_RST_ACCEL_BIT];
               st_nxt.temp_rst = reg_wdata[PATH_RST_TEMP_BIT];
            end
            OFS_MOTION_CTRL:
            begin
               // Reserved bits are dropped so they read back as zero.
               st_nxt.mot_ctrl = reg_wdata & MOT_CTRL_MASK;
            end
            default:
            begin
               // Read-only and unmapped offsets change nothing.
               st_nxt.mot_ctrl = st_r.mot_ctrl;
            end
         endcase
      end

      // Read data; status reads have no side effect on the watermark flag.
      if (reg_rd)
      begin
         case (reg_addr)
            // Status and rate words.
            OFS_WM_STATUS: st_nxt.rdata = 8'(wm_if.flag) << WM_FLAG_BIT;
            OFS_GYRO_X_HIGH: st_nxt.rdata = st_r.rate_x_word[15:8];
            OFS_GYRO_X_LOW: st_nxt.rdata = st_r.rate_x_word[7:0];
            OFS_GYRO_Y_HIGH: st_nxt.rdata = st_r.rate_y_word[15:8];
            OFS_GYRO_Y_LOW: st_nxt.rdata = st_r.rate_y_word[7:0];
            OFS_GYRO_Z_HIGH: st_nxt.rdata = st_r.rate_z_word[15:8];
            OFS_GYRO_Z_LOW: st_nxt.rdata = st_r.rate_z_word[7:0];
            // Stored settings read back as stored; the unkept high threshold bits 7:2 read as zero.
            OFS_FACTORY_ST_X: st_nxt.rdata = st_r.st_x;
            OFS_FACTORY_ST_Y: st_nxt.rdata = st_r.st_y;
            OFS_FACTORY_ST_Z: st_nxt.rdata = st_r.st_z;
            OFS_WM_THRESH_HIGH: st_nxt.rdata = {6'h00, st_r.thr_high};
            OFS_WM_THRESH_LOW: st_nxt.rdata = st_r.thr_low;
            // Path reset bits are pulses, so they read as zero.
            OFS_PATH_RESET: st_nxt.rdata = 8'h00;
            OFS_MOTION_CTRL: st_nxt.rdata = st_r.mot_ctrl;
            // The queue byte comes straight from storage.
            OFS_FIFO_DATA: st_nxt.rdata = fifo_rdata;
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // Motion decision is only produced while detection is enabled.
      // Axis hits are taken as levels; edge finding is left to the datapath.
      st_nxt.motion = st_r.mot_ctrl[MOT_EN_BIT] && st_r.mot_ctrl[MOT_COMPARE_BIT]
                      && combine_axes(axis_over, axis_enable,
                                      st_r.mot_ctrl[MOT_COMBINE_BIT]);
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= '{
            rate_x_word: '0,
            rate_y_word: '0,
            rate_z_word: '0,
            st_loaded: 1'b0,
            st_x: '0,
            st_y: '0,
            st_z: '0,
            thr_high: THR_RESET[1:0],
            thr_low: THR_RESET,
            mot_ctrl: MOT_CTRL_RESET,
            accel_rst: 1'b0,
            temp_rst: 1'b0,
            rdata: '0,
            rvalid: 1'b0,
            pop: 1'b0,
            motion: 1'b0
         };
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, all from flip-flops.
   // ----------------------------------------------------------------

   // Bus answer and queue pop.
   assign reg_rdata = st_r.rdata;
   assign reg_rvalid = st_r.rvalid;
   assign fifo_pop = st_r.pop;

   // The interrupt pin is a flop inside the engine.
   assign int_pin = wm_if.pin;

   // Path reset pulses.
   assign accel_path_reset = st_r.accel_rst;
   assign temp_path_reset = st_r.temp_rst;

   // Motion control copies and decision.
   assign motion_detect_enable = st_r.mot_ctrl[MOT_EN_BIT];
   assign motion_compare_mode = st_r.mot_ctrl[MOT_COMPARE_BIT];
   assign output_unlimit = st_r.mot_ctrl[MOT_UNLIMIT_BIT];
   assign motion_axis_combine = st_r.mot_ctrl[MOT_COMBINE_BIT];
   assign motion_event = st_r.motion;

endmodule // msr_regs
`default_nettype wire

// >>> verification/msr_regs_monitor.sv
`default_nettype none
module msr_regs_monitor
   import msr_pkg::*;
#(
   parameter int unsigned PULSE_CYC = WM_PULSE_CYC
)
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic arst_n,
   // Register port.
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic xfer_end,
   input wire logic reg_rvalid,
   // Queue, pin and path resets.
   input wire logic [15:0] fifo_count,
   input wire logic fifo_pop,
   input wire logic int_latch_mode,
   input wire logic int_pin,
   input wire logic accel_path_reset,
   input wire logic temp_path_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shadow threshold, read window and run length of a high pin.
   typedef struct packed {logic [9:0] thr; logic win; logic [15:0] hi;} msr_mon_t;
   msr_mon_t s_r;
   msr_mon_t s_nxt;
   logic rd_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------------------------------
   // Shadow of the threshold and of the queue read window.
   // ----------------------------------------------------------------
   // A data read of the queue, the event that opens the window.
   assign rd_q = reg_rd && reg_addr == OFS_FIFO_DATA;
   // The window closes in the end cycle, so a read there opens and closes it.
   always_comb
   begin
      s_nxt = s_r;
      if (reg_wr && reg_addr == OFS_WM_THRESH_HIGH)
         s_nxt.thr[9:8] = reg_wdata[1:0];
      if (reg_wr && reg_addr == OFS_WM_THRESH_LOW)
         s_nxt.thr[7:0] = reg_wdata;
      s_nxt.win = (s_r.win || rd_q) && !xfer_end;
      s_nxt.hi = int_pin ? s_r.hi + 16'h0001 : 16'h0000;
   end
   // Registers the shadow state.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   a_rd_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read without answer");
   a_pop_cause: assert property (fifo_pop |-> $past(rd_q))
      else $error("pop without data read");
   a_pop_after: assert property (rd_q |=> fifo_pop)
      else $error("data read without pop");
   a_accel_rst: assert property (reg_wr && reg_addr == OFS_PATH_RESET |=>
      accel_path_reset == $past(reg_wdata[PATH_RST_ACCEL_BIT]))
      else $error("accel path reset wrong");
   a_temp_rst: assert property (temp_path_reset |-> $past(reg_wr &&
      reg_addr == OFS_PATH_RESET && reg_wdata[PATH_RST_TEMP_BIT]))
      else $error("temp path reset without cause");
   // The run is counted, so any pulse width parameter is checked.
   a_pulse_len: assert property ($fell(int_pin) && !int_latch_mode |->
      s_r.hi == 16'(PULSE_CYC))
      else $error("pulse width wrong");
   a_pulse_max: assert property (int_pin && !int_latch_mode |->
      s_r.hi < 16'(PULSE_CYC))
      else $error("pulse too long");
   a_latch_clear: assert property (int_pin && int_latch_mode && rd_q |=> !int_pin)
      else $error("latched pin not cleared");
   a_latch_wait: assert property ($rose(int_pin) |-> $past(!s_r.win && !rd_q))
      else $error("pin rose inside read window");
   a_trig_cause: assert property ($rose(int_pin) |->
      $past(s_r.thr != 10'h000 && fifo_count >= 16'(s_r.thr)))
      else $error("pin rose without level");
   // Main scenarios.
   c_latch: cover property ($rose(int_pin) && int_latch_mode);
   c_pulse: cover property ($rose(int_pin) && !int_latch_mode);
   c_accel: cover property (accel_path_reset);
endmodule // msr_regs_monitor

bind msr_regs msr_regs_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.clk_sys(clk_sys),
   .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .xfer_end(xfer_end), .reg_rvalid(reg_rvalid),
   .fifo_count(fifo_count), .fifo_pop(fifo_pop), .int_latch_mode(int_latch_mode),
   .int_pin(int_pin), .accel_path_reset(accel_path_reset),
   .temp_path_reset(temp_path_reset));
`default_nettype wire

// >>> verification/msr_host_model.sv
`default_nettype none
module msr_host_model
   import msr_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Register port toward the device.
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   output logic xfer_end,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Host side of the serial engine; it never touches 0x1A.
   // ----------------------------------------------------------------
   // Idle values at time zero.
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      xfer_end = 1'b0;
   end
   // Released lines show the inverse so stale values never pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // The answer is registered, so it stands at the following falling edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
   // Ends the serial transaction and with it any queue read.
   task automatic endx();
      @(negedge clk_sys);
      xfer_end = 1'b1;
      @(negedge clk_sys);
      xfer_end = 1'b0;
   endtask
endmodule // msr_host_model
`default_nettype wire

// >>> verification/tb.sv
`default_nettype none
module tb
   import msr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, arst_n, reg_wr, reg_rd, xfer_end, reg_rvalid, sample_valid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_rdata;
   logic [15:0] rate [3];
   logic [15:0] exp_w [3];
   logic [15:0] fifo_count;
   logic fifo_pop, int_latch_mode, int_pin, accel_path_reset, temp_path_reset;
   logic [2:0] axis_over, axis_enable;
   logic mde, mcm, oul, mac, motion_event;
   int n_mismatch = 0;
   int n_compared = 0;
   int cnt;

   // ----------------------------------------------------------------
   // Clock, design and host.
   // ----------------------------------------------------------------
   // 125 MHz system clock.
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Short pulse parameter keeps the pulse test brief.
   msr_regs #(.PULSE_CYC(8)) dut (.clk_sys(clk_sys), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .xfer_end(xfer_end), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .sample_valid(sample_valid), .rate_x_in(rate[0]), .rate_y_in(rate[1]),
      .rate_z_in(rate[2]), .x_factory_test_value(8'h5A), .y_factory_test_value(8'hA5),
      .z_factory_test_value(8'h0F), .fifo_count(fifo_count), .fifo_rdata(fifo_rdata),
      .fifo_pop(fifo_pop), .int_latch_mode(int_latch_mode), .int_pin(int_pin),
      .accel_path_reset(accel_path_reset), .temp_path_reset(temp_path_reset),
      .axis_over(axis_over), .axis_enable(axis_enable), .motion_detect_enable(mde),
      .motion_compare_mode(mcm), .output_unlimit(oul), .motion_axis_combine(mac),
      .motion_event(motion_event));
   msr_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .xfer_end(xfer_end),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // Reads one register and expects a valid answer with the given byte.
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      chk(16'({v, d}), 16'({1'b1, e}));
   endtask
   // One new rate sample, then all six bytes against exp_w.
   task automatic gyro();
      @(negedge clk_sys);
      sample_valid = 1'b1;
      @(negedge clk_sys);
      sample_valid = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         rdc(OFS_GYRO_X_HIGH + 8'(2 * i), exp_w[i][15:8]);
         rdc(OFS_GYRO_X_LOW + 8'(2 * i), exp_w[i][7:0]);
      end
   endtask
   // Clears the flag by a queue read while the level is below any threshold.
   task automatic drain();
      fifo_count = 16'h0000;
      rdc(OFS_FIFO_DATA, 8'h99);
      host.endx();
   endtask
   task automatic summarize();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests.
   // ----------------------------------------------------------------
   // Main sequence; each test prints one line as it ends.
   initial
   begin
      arst_n = 1'b0;
      sample_valid = 1'b0;
      rate = '{16'h1234, 16'h8001, 16'h7FFF};
      fifo_count = 16'h0000;
      fifo_rdata = 8'h99;
      int_latch_mode = 1'b1;
      axis_over = 3'b001;
      axis_enable = 3'b011;
      repeat (20) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (2) @(negedge clk_sys);
      rdc(OFS_WM_THRESH_HIGH, THR_RESET);
      rdc(OFS_WM_THRESH_LOW, THR_RESET);
      rdc(OFS_MOTION_CTRL, MOT_CTRL_RESET);
      rdc(OFS_FACTORY_ST_X, 8'h5A);
      rdc(OFS_FACTORY_ST_Y, 8'hA5);
      host.wr(OFS_FACTORY_ST_Z, 8'h3C);
      rdc(OFS_FACTORY_ST_Z, 8'h3C);
      rdc(8'h00, 8'h00);
      $display("test reset and self-test done");
      exp_w = '{16'h1234, 16'h8001, RATE_LIMITED};
      gyro();
      host.wr(OFS_MOTION_CTRL, 8'hC2);
      exp_w[2] = RATE_LIMIT;
      gyro();
      host.wr(OFS_PATH_RESET, 8'h03);
      chk(16'({accel_path_reset, temp_path_reset}), 16'h0003);
      host.wr(OFS_PATH_RESET, 8'h02);
      chk(16'({accel_path_reset, temp_path_reset}), 16'h0002);
      for (int i = 0; i < 6; i++)
         rdc(OFS_GYRO_X_HIGH + 8'(i), i[0] ? exp_w[i / 2][7:0] : exp_w[i / 2][15:8]);
      $display("test rate words and path reset done");
      repeat (2) @(negedge clk_sys);
      chk(16'({mde, mcm, oul, mac, motion_event}), 16'h001D);
      host.wr(OFS_MOTION_CTRL, 8'hC3);
      repeat (2) @(negedge clk_sys);
      chk(16'({mac, motion_event}), 16'h0002);
      axis_over = 3'b011;
      repeat (2) @(negedge clk_sys);
      chk(16'(motion_event), 16'h0001);
      rdc(OFS_MOTION_CTRL, 8'hC3);
      host.wr(OFS_MOTION_CTRL, 8'h43);
      repeat (2) @(negedge clk_sys);
      chk(16'({mde, motion_event}), 16'h0000);
      $display("test motion control done");
      host.wr(OFS_WM_THRESH_HIGH, 8'h02);
      host.wr(OFS_WM_THRESH_LOW, 8'h01);
      fifo_count = 16'h0200;
      repeat (3) @(negedge clk_sys);
      chk(16'(int_pin), 16'h0000);
      fifo_count = 16'h0201;
      repeat (2) @(negedge clk_sys);
      chk(16'(int_pin), 16'h0001);
      rdc(OFS_WM_STATUS, 8'h40);
      rdc(OFS_WM_STATUS, 8'h40);
      rdc(OFS_FIFO_DATA, 8'h99);
      chk(16'(int_pin), 16'h0000);
      rdc(OFS_WM_STATUS, 8'h00);
      rdc(OFS_FIFO_DATA, 8'h99);
      host.endx();
      chk(16'(int_pin), 16'h0000);
      repeat (2) @(negedge clk_sys);
      chk(16'(int_pin), 16'h0001);
      rdc(OFS_WM_STATUS, 8'h40);
      $display("test latched watermark done");
      drain();
      int_latch_mode = 1'b0;
      fifo_count = 16'h03FF;
      cnt = 0;
      for (int i = 0; i < 10 && int_pin !== 1'b1; i++)
         @(negedge clk_sys);
      while (int_pin === 1'b1 && cnt < 20)
      begin
         cnt++;
         @(negedge clk_sys);
      end
      chk(16'(cnt), 16'h0008);
      rdc(OFS_WM_STATUS, 8'h40);
      $display("test pulsed watermark done");
      drain();
      host.wr(OFS_WM_THRESH_HIGH, 8'h00);
      host.wr(OFS_WM_THRESH_LOW, 8'h00);
      fifo_count = 16'h03FF;
      repeat (4) @(negedge clk_sys);
      chk(16'(int_pin), 16'h0000);
      rdc(OFS_WM_STATUS, 8'h00);
      $display("test zero threshold done");
      summarize();
   end
   // Watchdog: the whole sequence takes under two microseconds.
   initial
   begin
      #100us;
      n_mismatch++;
      summarize();
   end
endmodule // tb
`default_nettype wire
